// File: hdl/opg_programmer.sv
// otp prom programmer: program, verify-reprogram, final check, id read
//
// Function
// - program strobe pulse nominal 100 us, kept within 95 to 105 us
// - address starts at lowest location before any program pulse
// - supplies at 6.5 V / 13.0 V through program and verify passes
// - first pass: one pulse per address, no read-back
// - then verify-and-reprogram loop, address by address
// - on mismatch up to 10 extra pulses, verify after each
// - still mismatching after 10th extra pulse: stop, part failed
// - byte verifies: next address until all checked
// - supplies back to 5.0 V, read all, compare, declare pass/fail
// - wait 150 ns after output drive, 130 ns after release
// - id mode: all address low except id line high and selector
`timescale 1ns/1ps
`default_nettype none
module opg_programmer
  import opg_pkg::*;
#(
  parameter int unsigned LAST_ADDR = (1 << ADDR_W) - 1,
  parameter int unsigned PULSE_CYCLES = PULSE_CYC
) (
  // clock and reset
  input  wire logic              clk_sys_in,
  input  wire logic              sys_rst_in,
  // user: image load and commands
  input  wire logic              img_wr_in,
  input  wire logic [ADDR_W-1:0] img_addr_in,
  input  wire logic [DATA_W-1:0] img_data_in,
  input  wire logic              start_prog_in,
  input  wire logic              start_id_in,
  output logic                   busy_out,
  output opg_result_s            result_out,
  output logic [DATA_W-1:0]      maker_code_out,
  output logic [DATA_W-1:0]      device_code_out,
  // memory pins
  output opg_pins_s              pins_out,
  output logic [DATA_W-1:0]      data_o_out,
  output logic                   data_oe_n_out,
  input  wire logic [DATA_W-1:0] data_i_in,
  output opg_supply_e            supply_out
);
  // refuse a pulse outside the legal window or counts that cannot fit
  if (PULSE_CYCLES * CLK_PERIOD_PS < PULSE_MIN_NS * 1000 ||
      PULSE_CYCLES * CLK_PERIOD_PS > PULSE_MAX_NS * 1000 ||
      PULSE_CYCLES >= (1 << CNT_W) ||
      LAST_ADDR >= (1 << ADDR_W)) begin : g_bad_param
    $error("opg_programmer: bad parameter");
  end

  typedef enum logic [3:0] {
    S_IDLE, S_SETUP, S_PULSE, S_HOLD, S_RD_WAIT, S_RD_SAMPLE,
    S_RELEASE, S_NEXT, S_DONE
  } opg_state_e;
  typedef enum logic [1:0] {P_FIRST, P_VERIFY, P_FINAL, P_ID} opg_pass_e;

  logic [DATA_W-1:0] sync1_q, sync2_q;
  logic [DATA_W-1:0] img_q;
  opg_state_e        st_q, st_d;
  opg_pass_e         ps_q, ps_d;
  logic [CNT_W-1:0]  cnt_q, cnt_d;
  logic [3:0]        tries_q, tries_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  opg_result_s       res_q, res_d;
  opg_pins_s         pins_q, pins_d;
  opg_supply_e       sup_q, sup_d;
  logic              oe_n_q, oe_n_d;
  logic [DATA_W-1:0] mk_q, mk_d, dv_q, dv_d;

  function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
    cyc = CNT_W'(n - 1);
  endfunction

  opg_image_mem #(.AW(ADDR_W), .DW(DATA_W)) u_mem (
    .clk_sys_in  (clk_sys_in),
    .wr_en_in    (img_wr_in & (st_q == S_IDLE)),
    .wr_addr_in  (img_addr_in),
    .wr_data_in  (img_data_in),
    .rd_addr_in  (addr_q),
    .rd_data_out (img_q)
  );

  // data pins come from another part: two flops before use
  always_ff @(posedge clk_sys_in) begin
    sync1_q <= data_i_in;
    sync2_q <= sync1_q;
  end

  always_comb begin
    st_d = st_q; ps_d = ps_q; cnt_d = cnt_q; tries_d = tries_q;
    addr_d = addr_q; res_d = res_q; pins_d = pins_q; sup_d = sup_q;
    oe_n_d = oe_n_q; mk_d = mk_q; dv_d = dv_q;
    pins_d.addr = addr_q;
    if (cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
    end
    unique case (st_q)
      S_IDLE: begin
        pins_d = '{1'b1, 1'b1, 1'b1, 1'b0, ADDR_FIRST};
        oe_n_d = 1'b1;
        if (start_prog_in) begin
          addr_d = ADDR_FIRST;
          pins_d.addr = ADDR_FIRST;
          sup_d = OPG_SUP_PROG;
          ps_d = P_FIRST;
          res_d = '0;
          pins_d.chip_sel_n = 1'b0;
          cnt_d = cyc(SETUP_CYC);
          st_d = S_SETUP;
        end else if (start_id_in) begin
          addr_d = ADDR_FIRST;
          pins_d.addr = ADDR_FIRST;
          pins_d.id_mode_address_line = 1'b1;
          pins_d.chip_sel_n = 1'b0;
          sup_d = OPG_SUP_ID;
          ps_d = P_ID;
          res_d = '0;
          cnt_d = cyc(SETUP_CYC);
          st_d = S_RELEASE;
        end
      end
      S_SETUP: begin
        // address, data and supplies settle before the strobe
        // after a read the part may still drive: hold off our data
        if (cnt_q <= CNT_W'(SETUP_CYC)) begin
          oe_n_d = 1'b0;
        end
        if (cnt_q == '0) begin
          pins_d.program_strobe_n = 1'b0;
          cnt_d = cyc(PULSE_CYCLES);
          st_d = S_PULSE;
        end
      end
      S_PULSE: begin
        if (cnt_q == '0) begin
          pins_d.program_strobe_n = 1'b1;
          cnt_d = cyc(SETUP_CYC);
          st_d = S_HOLD;
        end
      end
      S_HOLD: begin
        if (cnt_q == '0) begin
          oe_n_d = 1'b1;
          cnt_d = cyc(SETUP_CYC);
          // first pass moves on without any read
          st_d = (ps_q == P_FIRST) ? S_NEXT : S_RELEASE;
        end
      end
      S_RELEASE: begin
        // our data drivers are off; wait before turning the part on
        oe_n_d = 1'b1;
        if (cnt_q == '0) begin
          pins_d.out_drive_n = 1'b0;
          pins_d.program_strobe_n = 1'b1;
          cnt_d = cyc(OUT_VALID_CYC + 2);
          st_d = S_RD_WAIT;
        end
      end
      S_RD_WAIT: begin
        // extra two cycles cover the input synchroniser
        if (cnt_q == '0) begin
          st_d = S_RD_SAMPLE;
        end
      end
      S_RD_SAMPLE: begin
        pins_d.out_drive_n = 1'b1;
        cnt_d = cyc(OUT_RELEASE_CYC);
        st_d = S_NEXT;
        if (ps_q == P_ID) begin
          if (addr_q[0]) dv_d = sync2_q;
          else mk_d = sync2_q;
        end else if (sync2_q != img_q) begin
          if (ps_q == P_FINAL) begin
            res_d.fail = 1'b1;
            res_d.fail_addr = addr_q;
          end else if (tries_q == 4'(MAX_EXTRA_PULSES)) begin
            res_d.fail = 1'b1;
            res_d.fail_addr = addr_q;
            st_d = S_DONE;
          end else begin
            tries_d = tries_q + 1'b1;
            st_d = S_RELEASE;
            cnt_d = cyc(OUT_RELEASE_CYC);
            ps_d = ps_q;
          end
        end
        // mismatch reprogram: release, then setup and pulse again
        if (ps_q == P_VERIFY && sync2_q != img_q &&
            tries_q != 4'(MAX_EXTRA_PULSES)) begin
          st_d = S_SETUP;
          cnt_d = cyc(OUT_RELEASE_CYC + SETUP_CYC);
        end
      end
      S_NEXT: begin
        if (cnt_q == '0) begin
          tries_d = '0;
          if (ps_q == P_ID) begin
            if (addr_q[0]) st_d = S_DONE;
            else begin
              addr_d = addr_q + 1'b1;
              cnt_d = cyc(SETUP_CYC);
              st_d = S_RELEASE;
            end
          end else if (addr_q != ADDR_W'(LAST_ADDR)) begin
            addr_d = addr_q + 1'b1;
            cnt_d = cyc(SETUP_CYC);
            st_d = (ps_q == P_FIRST) ? S_SETUP : S_RELEASE;
          end else if (ps_q == P_FIRST) begin
            ps_d = P_VERIFY;
            addr_d = ADDR_FIRST;
            cnt_d = cyc(SETUP_CYC);
            st_d = S_RELEASE;
          end else if (ps_q == P_VERIFY) begin
            ps_d = P_FINAL;
            sup_d = OPG_SUP_READ;
            addr_d = ADDR_FIRST;
            cnt_d = cyc(SETUP_CYC);
            st_d = S_RELEASE;
          end else begin
            st_d = S_DONE;
          end
        end
      end
      S_DONE: begin
        pins_d = '{1'b1, 1'b1, 1'b1, 1'b0, addr_q};
        oe_n_d = 1'b1;
        sup_d = OPG_SUP_READ;
        res_d.done = 1'b1;
        res_d.pass = (ps_q != P_ID) && !res_q.fail;
        st_d = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      st_q <= S_IDLE; ps_q <= P_FIRST; cnt_q <= '0; tries_q <= '0;
      addr_q <= '0; res_q <= '0; sup_q <= OPG_SUP_READ;
      pins_q <= '{1'b1, 1'b1, 1'b1, 1'b0, ADDR_FIRST};
      oe_n_q <= 1'b1; mk_q <= '0; dv_q <= '0;
    end else begin
      st_q <= st_d; ps_q <= ps_d; cnt_q <= cnt_d; tries_q <= tries_d;
      addr_q <= addr_d; res_q <= res_d; sup_q <= sup_d;
      pins_q <= pins_d; oe_n_q <= oe_n_d; mk_q <= mk_d; dv_q <= dv_d;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      busy_out <= 1'b0;
      result_out <= '0;
      pins_out <= '{1'b1, 1'b1, 1'b1, 1'b0, ADDR_FIRST};
      data_o_out <= '0;
      data_oe_n_out <= 1'b1;
      supply_out <= OPG_SUP_READ;
      maker_code_out <= '0;
      device_code_out <= '0;
    end else begin
      busy_out <= (st_d != S_IDLE);
      result_out <= res_d;
      pins_out <= pins_d;
      data_o_out <= img_q;
      data_oe_n_out <= oe_n_d;
      supply_out <= sup_d;
      maker_code_out <= mk_d;
      device_code_out <= dv_d;
    end
  end
endmodule
`default_nettype wire

// File: common/opg_pkg.sv
// package: constants, states and carriers for the otp programmer
`default_nettype none
package opg_pkg;
  localparam int unsigned CLK_PERIOD_PS   = 25000;
  // program pulse, nominal 100 us, legal 95..105 us
  localparam int unsigned PULSE_MIN_NS    = 95000;
  localparam int unsigned PULSE_MAX_NS    = 105000;
  localparam int unsigned PULSE_NOM_NS    = 100000;
  localparam int unsigned PULSE_CYC       =
    (PULSE_NOM_NS * 1000) / CLK_PERIOD_PS;
  // verify read timing
  localparam int unsigned OUT_VALID_NS    = 150;
  localparam int unsigned OUT_VALID_CYC   =
    (OUT_VALID_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned OUT_RELEASE_NS  = 130;
  localparam int unsigned OUT_RELEASE_CYC =
    (OUT_RELEASE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // setup / hold around each pulse and supply switching, 2 us
  localparam int unsigned SETUP_NS        = 2000;
  localparam int unsigned SETUP_CYC       =
    (SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned MAX_EXTRA_PULSES = 10;
  localparam int unsigned ADDR_W          = 17;
  localparam int unsigned DATA_W          = 8;
  localparam int unsigned CNT_W           = 16;
  localparam int unsigned ID_LINE_BIT     = 9;
  localparam logic [ADDR_W-1:0] ADDR_FIRST = 17'h00000;

  typedef enum logic [1:0] {
    OPG_SUP_READ, OPG_SUP_PROG, OPG_SUP_ID
  } opg_supply_e;

  typedef struct packed {
    logic                    chip_sel_n;
    logic                    out_drive_n;
    logic                    program_strobe_n;
    logic                    id_mode_address_line;
    logic [ADDR_W-1:0]       addr;
  } opg_pins_s;

  typedef struct packed {
    logic                    done;
    logic                    pass;
    logic                    fail;
    logic [ADDR_W-1:0]       fail_addr;
  } opg_result_s;
endpackage
`default_nettype wire

// File: hdl/opg_image_mem.sv
// source image memory, registered read data
`timescale 1ns/1ps
`default_nettype none
module opg_image_mem
  import opg_pkg::*;
#(
  parameter int unsigned AW = 17,
  parameter int unsigned DW = 8
) (
  // clock
  input  wire logic          clk_sys_in,
  // write port
  input  wire logic          wr_en_in,
  input  wire logic [AW-1:0] wr_addr_in,
  input  wire logic [DW-1:0] wr_data_in,
  // read port
  input  wire logic [AW-1:0] rd_addr_in,
  output var  logic [DW-1:0] rd_data_out
);
  logic [DW-1:0] mem_q [0:(1<<AW)-1];

  always_ff @(posedge clk_sys_in) begin
    if (wr_en_in) begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem_q[rd_addr_in];
  end
endmodule
`default_nettype wire

// File: tb/opg_programmer_sva.sv
// assertion checker on the programmer's memory pins
`timescale 1ns/1ps
`default_nettype none
module opg_programmer_sva
  import opg_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES = PULSE_CYC
) (
  input wire logic        clk_sys_in,
  input wire logic        sys_rst_in,
  input wire logic        busy_out,
  input wire opg_pins_s   pins_out,
  input wire logic        data_oe_n_out,
  input wire opg_supply_e supply_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  logic [CNT_W-1:0] low_q;
  logic [7:0]       drv_q;
  logic [7:0]       odh_q;
  logic             hit_q;
  // the idle counter odh_q saturates so long idle gaps never wrap
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      low_q <= '0;
      drv_q <= '0;
      odh_q <= '0;
      hit_q <= 1'h0;
    end else begin
      low_q <= pins_out.program_strobe_n ? '0 : low_q + 16'h1;
      drv_q <= pins_out.out_drive_n ? '0 : drv_q + 8'h1;
      odh_q <= !pins_out.out_drive_n ? '0 : odh_q + 8'(odh_q != 8'hFF);
      hit_q <= $rose(busy_out) ? 1'h0
             : (hit_q || $fell(pins_out.program_strobe_n));
    end
  end
  supply_prog_a: assert property (
    !pins_out.program_strobe_n |-> supply_out == OPG_SUP_PROG)
    else $error("strobe low without program supply");
  pulse_width_a: assert property (
    $rose(pins_out.program_strobe_n) |-> low_q == PULSE_CYCLES)
    else $error("program pulse width wrong");
  first_addr_a: assert property (
    $fell(pins_out.program_strobe_n) && !hit_q |-> pins_out.addr == ADDR_FIRST)
    else $error("first pulse not at lowest address");
  pulse_pins_a: assert property (
    !pins_out.program_strobe_n |-> !pins_out.chip_sel_n &&
      pins_out.out_drive_n && !data_oe_n_out)
    else $error("pulse without select or data");
  valid_wait_a: assert property (
    $rose(pins_out.out_drive_n) |-> drv_q >= OUT_VALID_CYC)
    else $error("read sampled too early");
  release_wait_a: assert property (
    $fell(data_oe_n_out) |-> odh_q >= OUT_RELEASE_CYC)
    else $error("data driven before output release");
  read_quiet_a: assert property (
    !pins_out.out_drive_n |-> pins_out.program_strobe_n &&
      !pins_out.chip_sel_n && data_oe_n_out)
    else $error("verify read with strobe or data on");
  id_pins_a: assert property (
    supply_out == OPG_SUP_ID && !pins_out.out_drive_n |->
      pins_out.id_mode_address_line && pins_out.addr[ADDR_W-1:1] == '0)
    else $error("id read address wrong");
  idle_supply_a: assert property (
    !busy_out |-> supply_out == OPG_SUP_READ)
    else $error("supplies not back to read level when idle");
endmodule
bind opg_programmer opg_programmer_sva #(.PULSE_CYCLES(PULSE_CYCLES)) u_sva (
  .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .busy_out(busy_out),
  .pins_out(pins_out), .data_oe_n_out(data_oe_n_out),
  .supply_out(supply_out));
`default_nettype wire

// File: tb/opg_prom_model.sv
// behavioural model of the one-time-programmable memory
`timescale 1ns/1ps
`default_nettype none
module opg_prom_model
  import opg_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE  = 8'hA5, // arbitrary value
  parameter logic [7:0] DEVICE_CODE = 8'h3C  // arbitrary value
) (
  // pins from the programmer
  input  wire opg_pins_s         pins_in,
  input  wire logic [DATA_W-1:0] data_in,
  input  wire opg_supply_e       supply_in,
  // read data to the programmer
  output wire logic [DATA_W-1:0] data_out
);
  logic [DATA_W-1:0] mem [0:3];
  logic [DATA_W-1:0] rd;
  logic [DATA_W-1:0] last = 8'h00;
  logic [1:0]        a;
  int                need [0:3];
  int                pulses [0:3];
  int                total_pulses = 0;
  int                bad_cnt = 0;
  bit                any_pulse = 0;
  realtime           t_fall = 0;
  wire reading = !pins_in.chip_sel_n && !pins_in.out_drive_n &&
                 pins_in.program_strobe_n;
  always @(negedge pins_in.program_strobe_n) t_fall = $realtime;
  always @(posedge pins_in.program_strobe_n) begin
    if (pins_in.chip_sel_n === 1'h0) begin
      a = pins_in.addr[1:0];
      if ($realtime - t_fall < PULSE_MIN_NS) bad_cnt++;
      if ($realtime - t_fall > PULSE_MAX_NS) bad_cnt++;
      if (!any_pulse && pins_in.addr !== ADDR_FIRST) bad_cnt++;
      if (supply_in !== OPG_SUP_PROG) bad_cnt++;
      any_pulse = 1;
      total_pulses++;
      pulses[a]++;
      if (pulses[a] > 11) bad_cnt++;
      // a weak cell ignores its first pulses; bits only ever clear
      if (pulses[a] > need[a]) mem[a] = mem[a] & data_in;
    end
  end
  always_comb rd = (supply_in == OPG_SUP_ID && pins_in.id_mode_address_line)
                   ? (pins_in.addr[0] ? DEVICE_CODE : MAKER_CODE)
                   : mem[pins_in.addr[1:0]];
  always @(reading or rd) if (reading) last = rd;
  // released bus shows the inverse of the last byte, never a held value
  // data appear only at the slowest legal output delay
  assign #(OUT_VALID_NS) data_out = reading ? rd : ~last;
endmodule
`default_nettype wire

// File: tb/tb_opg_programmer.sv
// self-checking bench for the otp programmer
`timescale 1ns/1ps
`default_nettype none
module tb_opg_programmer import opg_pkg::*;;
  localparam int unsigned LAST = 3;
  typedef struct {opg_result_s r; logic is_id;} opg_note_s;
  logic              clk_sys_in = 1'h0;
  logic              sys_rst_in = 1'h1;
  logic              img_wr_in = 1'h0;
  logic              start_prog_in = 1'h0;
  logic              start_id_in = 1'h0;
  logic [ADDR_W-1:0] img_addr_in = '0;
  logic [DATA_W-1:0] img_data_in = '0;
  logic [DATA_W-1:0] maker_code_out, device_code_out, data_o_out, data_i_in;
  logic              busy_out, data_oe_n_out, done_q = 1'h0;
  opg_result_s       result_out;
  opg_pins_s         pins_out;
  opg_supply_e       supply_out;
  logic [DATA_W-1:0] img [0:LAST];
  opg_note_s         exp_q[$];
  opg_note_s         n;
  int                num_errors = 0, checks = 0, cycles = 0, seed = 64;
  opg_programmer #(.LAST_ADDR(LAST), .PULSE_CYCLES(3800)) DUT (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .img_wr_in(img_wr_in),
    .img_addr_in(img_addr_in), .img_data_in(img_data_in),
    .start_prog_in(start_prog_in), .start_id_in(start_id_in),
    .busy_out(busy_out), .result_out(result_out),
    .maker_code_out(maker_code_out), .device_code_out(device_code_out),
    .pins_out(pins_out), .data_o_out(data_o_out),
    .data_oe_n_out(data_oe_n_out), .data_i_in(data_i_in),
    .supply_out(supply_out));
  opg_prom_model P (.pins_in(pins_out), .data_in(data_o_out),
    .supply_in(supply_out), .data_out(data_i_in));
  initial forever #12.5 clk_sys_in = ~clk_sys_in;
  task automatic cmp_val(input string nm, input logic [19:0] e, g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_res(input opg_result_s e, g);
    cmp_val("result", {e.done, e.pass, e.fail, e.fail ? e.fail_addr : 17'h0},
            {g.done, g.pass, g.fail, g.fail ? g.fail_addr : 17'h0});
  endtask
  task automatic summarize();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // fresh blank part; need1/need2 = ignored pulses at addresses 1 and 2
  task automatic load(input int need1, input int need2);
    for (int i = 0; i <= LAST; i++) begin
      img[i] = 8'($random(seed)) & 8'h7F; // never blank: every byte programs
      P.mem[i] = 8'hFF;
      P.need[i] = 0;
      P.pulses[i] = 0;
      @(negedge clk_sys_in);
      img_wr_in = 1'h1;
      img_addr_in = 17'(i);
      img_data_in = img[i];
    end
    P.need[1] = need1;
    P.need[2] = need2;
    P.total_pulses = 0;
    P.any_pulse = 0;
    @(negedge clk_sys_in);
    img_wr_in = 1'h0;
    img_addr_in = '0;
  endtask
  task automatic run(input logic id, input opg_result_s e);
    exp_q.push_back('{e, id});
    @(negedge clk_sys_in);
    start_prog_in = !id;
    start_id_in = id;
    @(negedge clk_sys_in);
    start_prog_in = 1'h0;
    start_id_in = 1'h0;
    if (!id) begin
      repeat (100) @(negedge clk_sys_in);
      start_id_in = 1'h1;
      img_wr_in = 1'h1;
      img_data_in = ~img[0];
      @(negedge clk_sys_in);
      start_id_in = 1'h0;
      img_wr_in = 1'h0;
    end
    while (busy_out === 1'h1) @(negedge clk_sys_in);
    repeat (4) @(negedge clk_sys_in);
  endtask
  always @(posedge clk_sys_in) begin
    done_q <= result_out.done;
    if (result_out.done === 1'h1 && done_q === 1'h0) begin
      n = exp_q.pop_front();
      cmp_res(n.r, result_out);
      cmp_val("busy", 20'h0, 20'(busy_out));
      if (n.is_id) cmp_val("maker", 20'hA5, 20'(maker_code_out));
      if (n.is_id) cmp_val("device", 20'h3C, 20'(device_code_out));
    end
  end
  // longest run is the stuck byte: 14 pulses of about 4000 cycles each
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 99000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    repeat (10) @(negedge clk_sys_in);
    sys_rst_in = 1'h0;
    load(0, 3);
    run(1'h0, '{1'h1, 1'h1, 1'h0, 17'h0});
    cmp_val("pulses", 20'h7, 20'(P.total_pulses));
    load(99, 0);
    run(1'h0, '{1'h1, 1'h0, 1'h1, 17'h1});
    cmp_val("pulses", 20'hE, 20'(P.total_pulses));
    run(1'h1, '{1'h1, 1'h0, 1'h0, 17'h0});
    cmp_val("model faults", 20'h0, 20'(P.bad_cnt));
    cmp_val("pending", 20'h0, 20'(exp_q.size()));
    summarize();
  end
endmodule
`default_nettype wire
